// File: verilog/rfc_pkg.sv
/*
  constants, register map and state types of the rf field and nfc mode control block.
  assumes a 200 MHz ref_clk_i and an AXI4-Lite master with 32-bit data.
*/
// Behaviour
// - carrier stays off after reset until the host sends field on
// - field on first runs external field detection for the initial delay time
// - external field seen during detection: carrier off, collision irq, cause recorded
// - field off instruction from the host switches the carrier off
// - active peer mode is chosen by the C_ACT bit of the control register
// - card mode does type A activation itself and flags it by irq
// - card mode answers by load modulation at 106 to 848 kbit/s
// - mode detector classifies a sensed field as type A or Manchester
// - peer mode runs active or passive at 106, 212 and 424 kbit/s
// - 106 uses full ASK with Miller, higher rates Manchester with partial ASK unless C_M100 forces full ASK
// - both antenna drivers carry the carrier, each can be inverted
// - transmitter offers full modulation and selectable amplitude levels
`default_nettype none
package rfc_pkg;
  localparam int          ADDR_W    = 6;
  localparam logic [5:0]  A_CTRL    = 6'h00;
  localparam logic [5:0]  A_CMD     = 6'h04;
  localparam logic [5:0]  A_STAT    = 6'h08;
  localparam logic [5:0]  A_IRQ_ST  = 6'h0C;
  localparam logic [5:0]  A_IRQ_CLR = 6'h10;
  localparam logic [5:0]  A_IRQ_EN  = 6'h14;
  localparam logic [5:0]  A_IDT     = 6'h18;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  // command register bits
  localparam int CMD_ON  = 0;
  localparam int CMD_OFF = 1;
  // control register fields
  localparam int C_ACT   = 0;
  localparam int C_INIT  = 1;
  localparam int C_CARD  = 2;
  localparam int C_RATE  = 3;
  localparam int C_INV_A = 5;
  localparam int C_INV_B = 6;
  localparam int C_AM    = 8;
  localparam int C_M100  = 13;
  localparam int CTRL_W  = 14;
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
  // interrupt bits
  localparam int I_COLL = 0;
  localparam int I_CARD = 1;
  localparam int I_MODE = 2;
  localparam int I_ON   = 3;
  localparam int NIRQ   = 4;
  // status bits
  localparam int S_ON   = 0;
  localparam int S_DET  = 1;
  localparam int S_COLL = 2;
  localparam int S_EXT  = 3;
  localparam int S_MD   = 4;
  localparam int S_CARD = 6;
  localparam int S_ACTV = 7;
  localparam logic [1:0] MD_NONE = 2'h0;
  localparam logic [1:0] MD_A    = 2'h1;
  localparam logic [1:0] MD_MAN  = 2'h2;
  localparam logic [1:0] RATE_106 = 2'h0;
  // type A card activation frames
  localparam logic [7:0] F_REQA = 8'h26;
  localparam logic [7:0] F_WUPA = 8'h52;
  localparam logic [7:0] F_SEL1 = 8'h93;
  localparam logic [7:0] F_NVB  = 8'h70;
  localparam logic [7:0] F_HLTA = 8'h50;
  // initial delay time
  localparam int CLK_NS  = 5;
  localparam int IDT_NS  = 100000;
  localparam int IDT_CYC = (IDT_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDT_W   = 24;
  typedef enum logic [1:0] {FS_OFF = 2'b00, FS_DET = 2'b01, FS_ON = 2'b10} rfc_field_t;
  typedef enum logic [1:0] {CS_IDLE = 2'b00, CS_READY = 2'b01, CS_SEL = 2'b10,
                            CS_ACT = 2'b11} rfc_card_t;
endpackage
`default_nettype wire

// File: verilog/rfc_field_ctrl.sv
/*
  rf field sequencing, mode detection, type A card activation and antenna drive,
  with an AXI4-Lite register slave and one level interrupt.
  assumes ext_field_i, rx_pause_i, rx_manch_i and carrier_i are asynchronous pins;
  rx_valid_i, rx_byte_i and tx_env_i come from coder logic on ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module rfc_field_ctrl
  import rfc_pkg::*;
#(
  parameter int IDT_DEF = IDT_CYC
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              clk_en_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              ext_field_i,
  input  wire logic              rx_pause_i,
  input  wire logic              rx_manch_i,
  input  wire logic              carrier_i,
  input  wire logic              rx_valid_i,
  input  wire logic [7:0]        rx_byte_i,
  input  wire logic              tx_env_i,
  output logic                   antenna_driver_a_o,
  output logic                   antenna_driver_b_o,
  output logic [4:0]             am_level_o,
  output logic                   mod_full_o,
  output logic                   miller_o,
  output logic                   load_mod_o,
  output logic                   field_on_o,
  output logic                   irq_o
);

  logic [3:0]        sync1;
  logic [3:0]        sync2;
  logic              ext_s;
  logic              pause_s;
  logic              manch_s;
  logic              carr_s;
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic [IDT_W-1:0]  idt;
  logic [IDT_W-1:0]  next_idt;
  logic [NIRQ-1:0]   irq_st;
  logic [NIRQ-1:0]   next_irq_st;
  logic [NIRQ-1:0]   irq_en;
  logic [NIRQ-1:0]   next_irq_en;
  logic              bvalid;
  logic              next_bvalid;
  logic [1:0]        bresp;
  logic [1:0]        next_bresp;
  logic              rvalid;
  logic              next_rvalid;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic [1:0]        rresp;
  logic [1:0]        next_rresp;
  rfc_field_t        fst;
  rfc_field_t        next_fst;
  logic [IDT_W-1:0]  cnt;
  logic [IDT_W-1:0]  next_cnt;
  logic              coll;
  logic              next_coll;
  logic [1:0]        md;
  logic [1:0]        next_md;
  rfc_card_t         cst;
  rfc_card_t         next_cst;
  logic              ant_a;
  logic              ant_b;
  logic              lmod;
  logic [4:0]        am;
  logic              next_ant_a;
  logic              next_ant_b;
  logic              next_lmod;
  logic [4:0]        next_am;
  logic              wr_go;
  logic              rd_go;
  logic              cmd_on;
  logic              cmd_off;
  logic              clr_hit;
  logic [NIRQ-1:0]   ev;
  logic              full_mod;
  logic              card_mode;

  // two-flop synchroniser for the pins; only sync2 is read by logic
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end
    else if (clk_en_i)
    begin
      sync1 <= {carrier_i, rx_manch_i, rx_pause_i, ext_field_i};
      sync2 <= sync1;
    end
  end

  assign ext_s   = sync2[0];
  assign pause_s = sync2[1];
  assign manch_s = sync2[2];
  assign carr_s  = sync2[3];

  // bus handshakes; address and data are taken together, one write at a time
  assign wr_go = clk_en_i & s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid;
  assign rd_go = clk_en_i & s_axi_arvalid_i & ~rvalid;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o  = wr_go;
  assign s_axi_arready_o = rd_go;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

  // instructions are single-cycle pulses decoded from the command register write
  assign cmd_on  = wr_go & (s_axi_awaddr_i == A_CMD) & s_axi_wstrb_i[0] & s_axi_wdata_i[CMD_ON];
  assign cmd_off = wr_go & (s_axi_awaddr_i == A_CMD) & s_axi_wstrb_i[0] & s_axi_wdata_i[CMD_OFF];
  assign clr_hit = wr_go & (s_axi_awaddr_i == A_IRQ_CLR) & s_axi_wstrb_i[0];
  assign card_mode = ctrl[C_CARD] & ~ctrl[C_INIT];

  // register file and bus answers
  always_comb
  begin
    next_ctrl   = ctrl;
    next_idt    = idt;
    next_irq_en = irq_en;
    next_bvalid = bvalid & ~s_axi_bready_i;
    next_bresp  = bresp;
    next_rvalid = rvalid & ~s_axi_rready_i;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (wr_go)
    begin
      next_bvalid = 1'b1;
      next_bresp  = RESP_OK;
      case (s_axi_awaddr_i)
        A_CTRL:
        begin
          if (s_axi_wstrb_i[0]) next_ctrl[7:0] = s_axi_wdata_i[7:0];
          if (s_axi_wstrb_i[1]) next_ctrl[CTRL_W-1:8] = s_axi_wdata_i[CTRL_W-1:8];
        end
        A_IRQ_EN:
        begin
          if (s_axi_wstrb_i[0]) next_irq_en = s_axi_wdata_i[NIRQ-1:0];
        end
        A_IDT:
        begin
          if (s_axi_wstrb_i[0]) next_idt[7:0] = s_axi_wdata_i[7:0];
          if (s_axi_wstrb_i[1]) next_idt[15:8] = s_axi_wdata_i[15:8];
          if (s_axi_wstrb_i[2]) next_idt[23:16] = s_axi_wdata_i[23:16];
        end
        A_CMD, A_IRQ_CLR: next_bresp = RESP_OK;
        default: next_bresp = RESP_ERR;
      endcase
    end
    if (rd_go)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OK;
      next_rdata  = 32'h0;
      case (s_axi_araddr_i)
        A_CTRL:    next_rdata[CTRL_W-1:0] = ctrl;
        A_STAT:
        begin
          next_rdata[S_ON]        = (fst == FS_ON);
          next_rdata[S_DET]       = (fst == FS_DET);
          next_rdata[S_COLL]      = coll;
          next_rdata[S_EXT]       = ext_s;
          next_rdata[S_MD+1:S_MD] = md;
          next_rdata[S_CARD]      = (cst == CS_ACT);
          next_rdata[S_ACTV]      = ctrl[C_ACT];
        end
        A_IRQ_ST:  next_rdata[NIRQ-1:0] = irq_st;
        A_IRQ_EN:  next_rdata[NIRQ-1:0] = irq_en;
        A_IDT:     next_rdata[IDT_W-1:0] = idt;
        A_CMD, A_IRQ_CLR: next_rresp = RESP_OK;
        default:   next_rresp = RESP_ERR;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl   <= CTRL_RST;
      idt    <= IDT_DEF[IDT_W-1:0];
      irq_en <= '0;
      bvalid <= 1'b0;
      bresp  <= RESP_OK;
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OK;
    end
    else if (clk_en_i)
    begin
      ctrl   <= next_ctrl;
      idt    <= next_idt;
      irq_en <= next_irq_en;
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // field sequencer: off, detection window, on
  always_comb
  begin
    next_fst = fst;
    next_cnt = cnt;
    next_coll = coll;
    ev = '0;
    case (fst)
      FS_OFF:
      begin
        if (cmd_on & ~cmd_off)
        begin
          next_fst  = FS_DET;
          next_cnt  = idt;
          next_coll = 1'b0;
        end
      end
      FS_DET:
      begin
        if (cmd_off)
          next_fst = FS_OFF;
        else if (ext_s)
        begin
          next_fst  = FS_OFF;
          next_coll = 1'b1;
          ev[I_COLL] = 1'b1;
        end
        else if (cnt == '0)
        begin
          next_fst = FS_ON;
          ev[I_ON] = 1'b1;
        end
        else
          next_cnt = cnt - 1'b1;
      end
      FS_ON:
      begin
        if (cmd_off) next_fst = FS_OFF;
      end
      default: next_fst = FS_OFF;
    endcase
    // mode detector only listens while our own field is off
    next_md = md;
    if (!ext_s || fst != FS_OFF)
      next_md = MD_NONE;
    else if (md == MD_NONE && pause_s)
      next_md = MD_A;
    else if (md == MD_NONE && manch_s)
      next_md = MD_MAN;
    ev[I_MODE] = (md == MD_NONE) & (next_md != MD_NONE);
    // layer-3 type A activation in card mode, the rest is left to the host
    next_cst = cst;
    if (!card_mode || !ext_s)
      next_cst = CS_IDLE;
    else if (rx_valid_i)
    begin
      case (cst)
        CS_IDLE:  if (rx_byte_i == F_REQA || rx_byte_i == F_WUPA) next_cst = CS_READY;
        CS_READY: if (rx_byte_i == F_SEL1) next_cst = CS_SEL;
        CS_SEL:   next_cst = (rx_byte_i == F_NVB) ? CS_ACT : CS_READY;
        CS_ACT:   if (rx_byte_i == F_HLTA) next_cst = CS_IDLE;
        default:  next_cst = CS_IDLE;
      endcase
    end
    ev[I_CARD] = (cst != CS_ACT) & (next_cst == CS_ACT);
    // sticky status: a new event wins over a clear in the same cycle
    next_irq_st = irq_st;
    if (clr_hit) next_irq_st = irq_st & ~s_axi_wdata_i[NIRQ-1:0];
    next_irq_st = next_irq_st | ev;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fst    <= FS_OFF;
      cnt    <= '0;
      coll   <= 1'b0;
      md     <= MD_NONE;
      cst    <= CS_IDLE;
      irq_st <= '0;
    end
    else if (clk_en_i)
    begin
      fst    <= next_fst;
      cnt    <= next_cnt;
      coll   <= next_coll;
      md     <= next_md;
      cst    <= next_cst;
      irq_st <= next_irq_st;
    end
  end

  // transmitter: 106 kbit/s uses full ASK, higher rates partial ASK unless forced
  assign full_mod = (ctrl[C_RATE+1:C_RATE] == RATE_106) | ctrl[C_M100];
  always_comb
  begin
    next_ant_a = 1'b0;
    next_ant_b = 1'b0;
    next_am    = 5'h00;
    next_lmod  = 1'b0;
    if (fst == FS_ON && (tx_env_i || !full_mod))
    begin
      next_ant_a = carr_s ^ ctrl[C_INV_A];
      next_ant_b = carr_s ^ ctrl[C_INV_B];
    end
    if (fst == FS_ON && !tx_env_i && !full_mod)
      next_am = ctrl[C_AM+4:C_AM];
    // card answers by loading the reader field, never by our own carrier
    if (card_mode && fst == FS_OFF && ext_s)
      next_lmod = ~tx_env_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ant_a <= 1'b0;
      ant_b <= 1'b0;
      am    <= 5'h00;
      lmod  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ant_a <= next_ant_a;
      ant_b <= next_ant_b;
      am    <= next_am;
      lmod  <= next_lmod;
    end
  end

  assign antenna_driver_a_o = ant_a;
  assign antenna_driver_b_o = ant_b;
  assign am_level_o = am;
  assign load_mod_o = lmod;
  assign mod_full_o = full_mod;
  assign miller_o   = (ctrl[C_RATE+1:C_RATE] == RATE_106);
  assign field_on_o = (fst == FS_ON);
  assign irq_o      = |(irq_st & irq_en);

endmodule
`default_nettype wire

// File: testbench/rfc_field_ctrl_sva.sv
/* port checker for rfc_field_ctrl.
   assumes bind into the design and a detection window of 8 cycles or more. */
`timescale 1ns/1ps
`default_nettype none
module rfc_field_ctrl_sva
  import rfc_pkg::*;
#(
  parameter int IDT_DEF = 8
)
(
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic [31:0]       s_axi_wdata_i,
  input wire logic [3:0]        s_axi_wstrb_i,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic              s_axi_rvalid_o,
  input wire logic              ext_field_i,
  input wire logic              antenna_driver_a_o,
  input wire logic              antenna_driver_b_o,
  input wire logic [4:0]        am_level_o,
  input wire logic              mod_full_o,
  input wire logic              miller_o,
  input wire logic              load_mod_o,
  input wire logic              field_on_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // accepted command writes; lane 0 carries both command bits
  wire logic aw_ok = s_axi_awvalid_i && s_axi_awready_o;
  wire logic cmd = aw_ok && s_axi_awaddr_i == A_CMD && s_axi_wstrb_i[0];
  property p_dark; cmd && s_axi_wdata_i[CMD_ON] && !field_on_o |=> !field_on_o [*8]; endproperty
  a_dark: assert property (p_dark) else $error("carrier on inside window");
  property p_ext; ext_field_i [*4] |-> !$rose(field_on_o); endproperty
  a_ext: assert property (p_ext) else $error("carrier on over field");
  property p_off; cmd && s_axi_wdata_i[CMD_OFF] |=> !field_on_o; endproperty
  a_off: assert property (p_off) else $error("carrier stays on");
  property p_quiet; !field_on_o && !$past(field_on_o) |->
    !antenna_driver_a_o && !antenna_driver_b_o && am_level_o == 5'h00; endproperty
  a_quiet: assert property (p_quiet) else $error("drive with field off");
  property p_mil; miller_o |-> mod_full_o; endproperty
  a_mil: assert property (p_mil) else $error("miller without full ask");
  property p_load; load_mod_o |-> !$past(field_on_o); endproperty
  a_load: assert property (p_load) else $error("load mod with own field");
  // sticky flags only drop through a clear or enable write
  property p_irq; $fell(irq_o) |-> $past(aw_ok); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped alone");
  property p_b; aw_ok |=> s_axi_bvalid_o; endproperty
  a_b: assert property (p_b) else $error("no write response");
  property p_r; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_r: assert property (p_r) else $error("no read response");
  c_on: cover property ($rose(field_on_o));
  c_irq: cover property ($rose(irq_o));
  c_load: cover property ($rose(load_mod_o));
endmodule
bind rfc_field_ctrl rfc_field_ctrl_sva #(.IDT_DEF(IDT_DEF)) sva_u (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .ext_field_i(ext_field_i), .antenna_driver_a_o(antenna_driver_a_o),
  .antenna_driver_b_o(antenna_driver_b_o), .am_level_o(am_level_o),
  .mod_full_o(mod_full_o), .miller_o(miller_o), .load_mod_o(load_mod_o),
  .field_on_o(field_on_o), .irq_o(irq_o));
`default_nettype wire

// File: testbench/rfc_peer_model.sv
/* remote peer: external field, pauses, Manchester activity, frame bytes.
   assumes clk_i is the device clock; carrier is a free reference. */
`timescale 1ns/1ps
`default_nettype none
module rfc_peer_model
(
  input  wire logic  clk_i,
  output logic       ext_o,
  output logic       pause_o,
  output logic       manch_o,
  output logic       carrier_o,
  output logic       rx_valid_o,
  output logic [7:0] rx_byte_o
);
  // idle levels: no field, no activity, byte lines all ones
  initial
  begin
    ext_o      = 1'b0;
    pause_o    = 1'b0;
    manch_o    = 1'b0;
    carrier_o  = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'hFF;
  end
  // roughly 13.5 MHz, unrelated to clk_i
  always #37 carrier_o = ~carrier_o;
  task automatic field(input logic on);
    @(posedge clk_i);
    ext_o <= on;
  endtask
  // one burst of type A pauses or of Manchester activity
  task automatic sig(input logic a);
    @(posedge clk_i);
    pause_o <= a;
    manch_o <= !a;
    repeat (4) @(posedge clk_i);
    pause_o <= 1'b0;
    manch_o <= 1'b0;
  endtask
  // byte lines invert after the strobe so stale data never looks valid
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~b;
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
/* self-checking bench for rfc_field_ctrl over AXI4-Lite.
   assumes a window of 8 cycles and wstrb tied on. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rfc_pkg::*;
  logic ref_clk_i = 0, rst_i = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, env = 1;
  logic ce = 1, wrdy;
  logic [5:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rdata;
  logic [1:0] bresp, rresp;
  logic awr, bv, arr, rv, ta, tb_o, mf, mil, lm, fon, irq, ext, pse, man, car, rxv;
  logic [4:0] am;
  logic [7:0] rxb;
  int n_errors = 0, n_checks = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  rfc_peer_model peer_u (.clk_i(ref_clk_i), .ext_o(ext), .pause_o(pse), .manch_o(man),
    .carrier_o(car), .rx_valid_o(rxv), .rx_byte_o(rxb));
  rfc_field_ctrl #(.IDT_DEF(8)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(ce),
    .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rrdy), .ext_field_i(ext), .rx_pause_i(pse), .rx_manch_i(man),
    .carrier_i(car), .rx_valid_i(rxv), .rx_byte_i(rxb), .tx_env_i(env),
    .antenna_driver_a_o(ta), .antenna_driver_b_o(tb_o), .am_level_o(am), .mod_full_o(mf),
    .miller_o(mil), .load_mod_o(lm), .field_on_o(fon), .irq_o(irq));
  task automatic chk(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // ready is looked at on the falling edge, so the taking edge is the next rising one
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
    @(posedge ref_clk_i);
    aw <= a; wd <= d; awv <= 1; wv <= 1; brdy <= 1;
    do @(negedge ref_clk_i); while (!(awr && wrdy));
    @(posedge ref_clk_i);
    awv <= 0; wv <= 0;
    do @(negedge ref_clk_i); while (!bv);
    chk(bresp, er, "bresp");
    @(posedge ref_clk_i);
    brdy <= 0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, m = '1,
                    input logic [1:0] er = RESP_OK);
    @(posedge ref_clk_i);
    ar <= a; arv <= 1; rrdy <= 1;
    do @(negedge ref_clk_i); while (!arr);
    @(posedge ref_clk_i);
    arv <= 0;
    do @(negedge ref_clk_i); while (!rv);
    chk(rdata & m, e, "rdata");
    chk(rresp, er, "rresp");
    @(posedge ref_clk_i);
    rrdy <= 0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard at 20000 cycles, well past the few hundred cycles the tests need
  initial
  begin
    #100us;
    n_errors++;
    end_sim();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 0;
    cyc(1);
    chk(fon, 0, "off after reset");
    rd(A_IDT, 8);
    rd(A_CTRL, 0);
    rd(6'h3C, 0, '1, RESP_ERR);
    wr(6'h3C, 1, RESP_ERR);
    $display("test reset done");
    wr(A_IRQ_EN, 32'hF);
    wr(A_CTRL, 32'h1 | (1 << C_INV_A));
    wr(A_CMD, 32'h1);
    cyc(1);
    chk(fon, 0, "detect first");
    // a low clock enable must stretch the window by the frozen cycles
    @(posedge ref_clk_i);
    ce <= 0;
    cyc(20);
    chk(fon, 0, "window frozen");
    @(posedge ref_clk_i);
    ce <= 1;
    cyc(12);
    chk(fon, 1, "on after window");
    chk(ta ^ tb_o, 1, "one driver inverted");
    rd(A_STAT, 32'h81, 32'h8F);
    rd(A_IRQ_ST, 32'h8, 32'hF);
    wr(A_IRQ_CLR, 32'h8);
    cyc(1);
    chk(irq, 0, "irq cleared");
    for (int r = 0; r < 3; r++)
    begin
      wr(A_CTRL, r << C_RATE);
      cyc(1);
      chk(mil, r == 0, "miller");
      chk(mf, r == 0, "full ask");
    end
    wr(A_CTRL, (1 << C_RATE) | (32'h11 << C_AM));
    @(posedge ref_clk_i);
    env <= 0;
    cyc(3);
    chk(am, 5'h11, "am level");
    wr(A_CTRL, (1 << C_RATE) | (1 << C_M100));
    cyc(1);
    chk(mf, 1, "forced full");
    @(posedge ref_clk_i);
    env <= 1;
    wr(A_CMD, 32'h2);
    cyc(1);
    chk(fon, 0, "off");
    $display("test field on off done");
    peer_u.field(1);
    cyc(4);
    wr(A_CMD, 32'h1);
    cyc(12);
    chk(fon, 0, "collision keeps off");
    rd(A_STAT, 32'hC, 32'hF);
    rd(A_IRQ_ST, 1, 1);
    chk(irq, 1, "collision irq");
    wr(A_IRQ_EN, 32'hE);
    cyc(1);
    chk(irq, 0, "irq masked");
    wr(A_IRQ_EN, 32'hF);
    wr(A_IRQ_CLR, 32'h1);
    peer_u.sig(1);
    cyc(4);
    rd(A_STAT, MD_A << S_MD, 32'h30);
    rd(A_IRQ_ST, 4, 4);
    peer_u.field(0);
    cyc(4);
    peer_u.field(1);
    peer_u.sig(0);
    cyc(4);
    rd(A_STAT, MD_MAN << S_MD, 32'h30);
    wr(A_IRQ_CLR, 32'hF);
    $display("test collision and mode done");
    wr(A_CTRL, 1 << C_CARD);
    peer_u.send(F_REQA);
    peer_u.send(F_SEL1);
    peer_u.send(F_NVB);
    rd(A_IRQ_ST, 2, 2);
    rd(A_STAT, 32'h40, 32'h40);
    // the sync byte is ordinary data and must not disturb the activated card
    peer_u.send(8'hF0);
    rd(A_STAT, 32'h40, 32'h40);
    @(posedge ref_clk_i);
    env <= 0;
    cyc(3);
    chk(lm, 1, "load modulation");
    @(posedge ref_clk_i);
    env <= 1;
    $display("test card done");
    end_sim();
  end
endmodule
`default_nettype wire
